// file: scfc_pkg.sv
// Constants and types for the 4-bit CRC frame check block
package scfc_pkg;

	// ****************************************
	// Frame and CRC geometry
	// ****************************************
	localparam int SCFC_FRAME_BITS = 32;
	localparam int SCFC_CNT_W = 6;
	localparam int SCFC_CRC_BITS = 4;
	localparam int SCFC_SRC_W = 3;
	localparam int SCFC_SRC_NUM = 8;

	// ****************************************
	// Field values
	// ****************************************
	localparam logic [1:0] SCFC_ST_ERROR = 2'h3;
	localparam logic [3:0] SCFC_MC_INIT = 4'h1;
	localparam logic [3:0] SCFC_CRC_ZERO = 4'h0;
	localparam logic [1:0] SCFC_PAD2 = 2'h0;
	localparam logic [3:0] SCFC_PAD4 = 4'h0;
	localparam logic [3:0] SCFC_ECHO_NONE = 4'h0;
	localparam logic [15:0] SCFC_DATA_NONE = 16'h0000;
	localparam logic [13:0] SCFC_SD_NONE = 14'h0000;
	localparam logic [5:0] SCFC_FRAME_LAST = 6'h1f;
	localparam logic [5:0] SCFC_FRAME_END = 6'h20;

	// ****************************************
	// Response kinds
	// ****************************************
	typedef enum logic [4:0] {
		SCFC_RK_REG = 5'h01,
		SCFC_RK_SENSOR = 5'h02,
		SCFC_RK_REG_ERR = 5'h04,
		SCFC_RK_SENS_ERR_DATA = 5'h08,
		SCFC_RK_SENS_ERR_NODATA = 5'h10
	} scfc_kind_t;

endpackage

// file: scfc_frame_check.sv
// Serial frame CRC-4 check, response CRC-4 generation and message counters
`timescale 1ns/100ps
// Functional notes
// - CRC-4 over all 32 command bits
// - Bits enter CRC MSB first
// - Failed command dropped, error response returned
// - Shift register preset from crc_seed_field
// - Message then CRC shifted into low end
// - Zero residue valid, nonzero is error
// - Polynomial x^4+1 seeded, both parties
// - Response CRC over full 32-bit frame
// - Seed, message, four zeros give CRC
// - Remainder inserted into response CRC field
// - Sensor responses with data carry message_counter in CRC-4 mode
// - Counter per source, advances, wraps at four bits
// - Each counter starts at 0001
// - CRC-4 only when selected, else bypass
module scfc_frame_check
	import scfc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic crc4_mode,
	input wire logic [3:0] crc_seed_field,
	output logic cmd_valid,
	output logic [SCFC_FRAME_BITS-1:0] cmd_word,
	output logic crc_error,
	output logic [3:0] last_residue,
	input wire logic resp_valid,
	input wire scfc_kind_t resp_kind,
	input wire logic [SCFC_SRC_W-1:0] source_select,
	input wire logic [1:0] basic_status_field,
	input wire logic [15:0] reg_data,
	input wire logic [11:0] sensor_sample,
	input wire logic [3:0] extra_resolution,
	input wire logic [1:0] detail_status_field,
	output logic [SCFC_FRAME_BITS-1:0] resp_word
);

	// ****************************************
	// Serial CRC, polynomial x^4 + 1
	// ****************************************
	function automatic logic [3:0] crc4_over(input logic [3:0] seed,
		input logic [SCFC_FRAME_BITS-1:0] word);
		logic [3:0] r;
		r = seed;
		for (int i = SCFC_FRAME_BITS - 1; i >= 0; i--) begin
			r = {r[2:0], r[3] ^ word[i]};
		end
		return r;
	endfunction

	// ****************************************
	// Link domain: receive shift and frame end
	// ****************************************
	logic [SCFC_CNT_W-1:0] bit_cnt;
	logic [SCFC_FRAME_BITS-1:0] rx_shift;
	logic [SCFC_FRAME_BITS-1:0] rx_word;
	logic frame_tgl;
	wire frame_last = (bit_cnt == SCFC_FRAME_LAST);
	wire in_frame = (bit_cnt < SCFC_FRAME_END);

	always_ff @(posedge sclk or posedge cs_n or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt <= '0;
		end else if (cs_n) begin
			bit_cnt <= '0;
		end else if (in_frame) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_shift <= '0;
			rx_word <= '0;
			frame_tgl <= 1'b0;
		end else if (!cs_n && in_frame) begin
			rx_shift <= {rx_shift[SCFC_FRAME_BITS-2:0], mosi};
			if (frame_last) begin
				rx_word <= {rx_shift[SCFC_FRAME_BITS-2:0], mosi};
				frame_tgl <= ~frame_tgl;
			end
		end
	end

	// Response word is held steady between frames; bit shown after each rising edge
	wire [4:0] tx_idx = 5'(SCFC_FRAME_LAST - bit_cnt);
	assign miso = (!cs_n && in_frame) ? resp_word[tx_idx] : 1'b0;
	assign miso_oe = !cs_n;

	// ****************************************
	// Crossing of frame event into clk
	// ****************************************
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_prev;
	wire frame_evt = tgl_sync ^ tgl_prev;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_prev <= 1'b0;
		end else if (ce) begin
			tgl_meta <= frame_tgl;
			tgl_sync <= tgl_meta;
			tgl_prev <= tgl_sync;
		end
	end

	// ****************************************
	// Command check
	// ****************************************
	wire [3:0] rx_residue = crc4_over(crc_seed_field, rx_word);
	wire rx_bad = crc4_mode && (rx_residue != SCFC_CRC_ZERO);
	wire cmd_take = frame_evt && !rx_bad;
	wire cmd_drop = frame_evt && rx_bad;
	logic [3:0] cmd_code;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid <= 1'b0;
			crc_error <= 1'b0;
			cmd_word <= '0;
			cmd_code <= '0;
			last_residue <= '0;
		end else if (ce) begin
			cmd_valid <= cmd_take;
			crc_error <= cmd_drop;
			if (frame_evt) begin
				last_residue <= rx_residue;
			end
			if (cmd_take) begin
				cmd_word <= rx_word;
				cmd_code <= rx_word[31:28];
			end
		end
	end

	// ****************************************
	// Message counters per source
	// ****************************************
	logic [3:0] msg_cnt [SCFC_SRC_NUM];
	wire is_sensor_data = (resp_kind == SCFC_RK_SENSOR) || (resp_kind == SCFC_RK_SENS_ERR_DATA);
	wire cnt_adv = ce && resp_valid && !cmd_drop && is_sensor_data && crc4_mode;

	genvar g;
	generate
		for (g = 0; g < SCFC_SRC_NUM; g++) begin : g_cnt
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					msg_cnt[g] <= SCFC_MC_INIT;
				end else if (cnt_adv && (source_select == SCFC_SRC_W'(g))) begin
					msg_cnt[g] <= msg_cnt[g] + 4'h1;
				end
			end
		end
	endgenerate

	// ****************************************
	// Response assembly
	// ****************************************
	wire [3:0] echo = {cmd_code[0], cmd_code[3], cmd_code[2], cmd_code[1]};
	wire [3:0] mc_field = crc4_mode ? msg_cnt[source_select] : SCFC_PAD4;
	wire [1:0] st_field = (resp_kind == SCFC_RK_REG || resp_kind == SCFC_RK_SENSOR) ?
		basic_status_field : SCFC_ST_ERROR;
	logic [SCFC_FRAME_BITS-1:0] body;

	always_comb begin
		body = '0;
		unique case (resp_kind)
			SCFC_RK_REG: begin
				body = {echo, st_field, SCFC_PAD2, reg_data, SCFC_PAD4, SCFC_CRC_ZERO};
			end
			SCFC_RK_REG_ERR: begin
				body = {SCFC_ECHO_NONE, st_field, SCFC_PAD2, reg_data, SCFC_PAD4,
					SCFC_CRC_ZERO};
			end
			SCFC_RK_SENSOR, SCFC_RK_SENS_ERR_DATA: begin
				body = {echo, st_field, sensor_sample, extra_resolution,
					detail_status_field, mc_field, SCFC_CRC_ZERO};
			end
			SCFC_RK_SENS_ERR_NODATA: begin
				body = {SCFC_ECHO_NONE, st_field, SCFC_DATA_NONE, detail_status_field,
					SCFC_PAD4, SCFC_CRC_ZERO};
			end
			default: begin
				body = '0;
			end
		endcase
	end

	// Error reply built by the block itself for a failed check
	wire [SCFC_FRAME_BITS-1:0] err_body = {SCFC_ECHO_NONE, SCFC_ST_ERROR, SCFC_PAD2,
		SCFC_DATA_NONE, SCFC_PAD4, SCFC_CRC_ZERO};
	wire [SCFC_FRAME_BITS-1:0] msg_sel = cmd_drop ? err_body : body;
	// Low nibble is zero, so this is message then four zero bits
	wire [3:0] tx_crc = crc4_over(crc_seed_field, msg_sel);
	wire [SCFC_FRAME_BITS-1:0] next_resp = crc4_mode ?
		{msg_sel[SCFC_FRAME_BITS-1:SCFC_CRC_BITS], tx_crc} : msg_sel;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resp_word <= '0;
		end else if (ce && (cmd_drop || resp_valid)) begin
			resp_word <= next_resp;
		end
	end

endmodule

// file: scfc_frame_check_properties.sv
// Assertions on the ports of the CRC-4 frame check block
`timescale 1ns/100ps
module scfc_frame_check_properties
	import scfc_pkg::*;
(
	input wire logic clk, arst_n, ce, sclk, cs_n, mosi, miso, miso_oe, crc4_mode,
	input wire logic cmd_valid, crc_error, resp_valid,
	input wire logic [3:0] crc_seed_field, last_residue, extra_resolution,
	input wire logic [SCFC_FRAME_BITS-1:0] cmd_word, resp_word,
	input wire scfc_kind_t resp_kind,
	input wire logic [SCFC_SRC_W-1:0] source_select,
	input wire logic [1:0] basic_status_field, detail_status_field,
	input wire logic [15:0] reg_data,
	input wire logic [11:0] sensor_sample
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	function automatic logic [3:0] crc(input logic [31:0] w, input logic [3:0] s);
		crc = s;
		for (int i = 1; i < 8; i++) crc ^= w[i*4+:4];
	endfunction
	a_bad_residue: assert property (crc_error |-> last_residue != 4'h0) else $error("residue");
	a_err_reply: assert property (crc_error |-> resp_word[31:4] == 28'h0c00000)
		else $error("error reply");
	a_resp_crc: assert property ($changed(resp_word) && crc4_mode
		|-> resp_word[3:0] == crc(resp_word, crc_seed_field)) else $error("crc");
	a_bypass_zero: assert property ($changed(resp_word) && !crc4_mode
		|-> resp_word[7:0] == 8'h00) else $error("bypass");
	a_err_status: assert property ($past(resp_valid && ce && |resp_kind[4:2])
		|-> resp_word[27:26] == 2'h3) else $error("status");
	a_reg_data: assert property ($past(resp_valid && ce && resp_kind == SCFC_RK_REG) && !crc_error
		|-> resp_word[25:4] == {2'h0, $past(reg_data), 4'h0}) else $error("reg");
	a_echo_order: assert property ($past(resp_valid && ce && |(resp_kind & 5'h0b)) && !crc_error
		|-> resp_word[31:28] == {cmd_word[28], cmd_word[31:29]}) else $error("echo");
	a_sensor_fields: assert property ($past(resp_valid && ce && resp_kind == SCFC_RK_SENSOR)
		&& !crc_error |-> resp_word[25:8] == {$past(sensor_sample),
		$past(extra_resolution), $past(detail_status_field)}) else $error("sensor");
	c_accept: cover property (cmd_valid);
	c_reject: cover property (crc_error);
	c_sensor: cover property (resp_valid && resp_kind == SCFC_RK_SENSOR);
endmodule
bind scfc_frame_check scfc_frame_check_properties chk (.*);

// file: scfc_host_model.sv
// Host serial controller model sending and receiving 32-bit frames
`timescale 1ns/100ps
module scfc_host_model (
	output logic sclk, cs_n, mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// ****************************************
	// Frame transfer, link clock only inside
	// ****************************************
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		cs_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			mosi = tx[i];
			#3 rx[i] = miso;
			sclk = 1'b1;
			#3 sclk = 1'b0;
		end
		#3 cs_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule

// file: scfc_frame_check_tb.sv
// Self-checking bench for the CRC-4 frame check block
`timescale 1ns/100ps
module scfc_frame_check_tb
	import scfc_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b0, crc4_mode = 1'b1, resp_valid = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, cmd_valid, crc_error;
	logic [3:0] crc_seed_field = 4'ha, last_residue, extra_resolution = 4'h5;
	logic [31:0] cmd_word, resp_word, rx, exp = 32'h0, acc = 32'h0;
	scfc_kind_t resp_kind = SCFC_RK_REG;
	logic [2:0] source_select = 3'h0;
	logic [1:0] basic_status_field = 2'h1, detail_status_field = 2'h2;
	logic [15:0] reg_data = 16'ha55a;
	logic [11:0] sensor_sample = 12'habc;
	logic [3:0] cnt [8] = '{default: 4'h1};
	int err_total = 0, n_checks = 0, n_ok = 0, cyc = 0;
	always #5 clk = ~clk;
	scfc_frame_check dut (.*);
	scfc_host_model host (.*);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude();
		if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cmd_valid === 1'b1) n_ok++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [3:0] crc(input logic [31:0] w, input logic [3:0] s);
		crc = s;
		for (int i = 1; i < 8; i++) crc ^= w[i*4+:4];
	endfunction
	task automatic frame(input logic [31:0] c, input logic bad);
		int ok;
		ok = n_ok;
		host.xfer(c, rx);
		chk("miso", rx, exp);
		repeat (8) @(negedge clk);
		chk("residue", last_residue, {3'h0, bad});
		if (bad && crc4_mode) begin
			exp = {4'h0, 2'h3, 22'h0, crc(32'h0c000000, crc_seed_field)};
			chk("error reply", resp_word, exp);
		end else acc = c;
		chk("accepted", n_ok - ok, !bad || !crc4_mode);
		chk("command", cmd_word, acc);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [7:0] a, d, input logic bad);
		logic [31:0] w;
		w = {op, 4'h0, a, d, 8'h0};
		w[3:0] = crc(w, crc_seed_field) ^ {3'h0, bad};
		frame(w, bad);
	endtask
	task automatic resp(input scfc_kind_t k, input logic [2:0] s);
		logic [31:0] w;
		logic [3:0] m;
		logic [3:0] e;
		m = 4'h0;
		e = {acc[28], acc[31:29]};
		if (crc4_mode && (k == SCFC_RK_SENSOR || k == SCFC_RK_SENS_ERR_DATA)) begin
			m = cnt[s];
			cnt[s] = cnt[s] + 4'h1;
		end
		w = {e, k[3] ? 2'h3 : basic_status_field, sensor_sample, extra_resolution,
			detail_status_field, m, 4'h0};
		if (k == SCFC_RK_REG) w = {e, basic_status_field, 2'h0, reg_data, 8'h0};
		if (k == SCFC_RK_REG_ERR) w = {6'h03, 2'h0, reg_data, 8'h0};
		if (k == SCFC_RK_SENS_ERR_NODATA) w = {6'h03, 16'h0, detail_status_field, 8'h0};
		w[3:0] = crc4_mode ? crc(w, crc_seed_field) : 4'h0;
		@(negedge clk);
		resp_kind = k;
		source_select = s;
		resp_valid = 1'b1;
		@(negedge clk);
		resp_valid = 1'b0;
		chk("response", resp_word, w);
		exp = w;
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		ce = 1'b1;
		frame(32'h8022c10f, 1'b0);
		cmd(4'h4, 8'h1f, 8'hc1, 1'b0);
		cmd(4'hc, 8'h22, 8'h00, 1'b1);
		crc_seed_field = 4'h5;
		cmd(4'h6, 8'hff, 8'h5a, 1'b0);
		for (int i = 0; i < 18; i++) resp(SCFC_RK_SENSOR, 3'h3);
		for (int k = 1; k < 32; k = k * 2) resp(scfc_kind_t'(k), 3'h5);
		cmd(4'h8, 8'h22, 8'hc1, 1'b0);
		crc4_mode = 1'b0;
		cmd(4'h4, 8'hff, 8'h5a, 1'b1);
		resp(SCFC_RK_SENSOR, 3'h3);
		cmd(4'hc, 8'h3e, 8'h00, 1'b0);
		conclude();
	end
endmodule
